// >>> include/osc_ctrl_pkg.sv
// Package with register map, field layout, mode codes and timing for oscillator control
package osc_ctrl_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TRIM = 8'h08;
	localparam logic [7:0] ADDR_CONFIG = 8'h0C;
	localparam int ADDR_W = 8;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_SCS_LSB = 0;
	localparam int CTL_INTERNAL_FREQ_SELECT_FIELD_LSB = 3;
	localparam int CTL_SPLL_BIT = 7;
	localparam logic [1:0] SCS_RESET = 2'h0;
	localparam logic [3:0] INTERNAL_FREQ_SELECT_FIELD_RESET = 4'h7;
	localparam logic [1:0] SCS_CONFIGURED = 2'h0;
	localparam logic [1:0] SCS_TIMER_XTAL = 2'h1;

	// ----------------------------------------------------------------
	// Status register bits
	// ----------------------------------------------------------------
	localparam int STS_START_BIT = 0;
	localparam int STS_LF_READY_BIT = 1;
	localparam int STS_HF_STABLE_BIT = 2;
	localparam int STS_HF_LOCKED_BIT = 3;
	localparam int STS_MF_READY_BIT = 4;
	localparam int STS_HF_READY_BIT = 5;

	// ----------------------------------------------------------------
	// Trim and configuration fields
	// ----------------------------------------------------------------
	localparam int TRIM_W = 6;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_PLL_BIT = 3;
	localparam int CFG_CLKOUT_BIT = 4;
	localparam int CFG_FAILSAFE_BIT = 5;
	localparam int CFG_TWOSPEED_BIT = 6;
	localparam int CFG_POWER_UP_DELAY_TIMER_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h04;

	// ----------------------------------------------------------------
	// Clock modes and frequency ranges
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_WATCH_XTAL = 3'b000,
		MODE_MED_XTAL = 3'b001,
		MODE_HIGH_XTAL = 3'b010,
		MODE_RES_CAP = 3'b011,
		MODE_INTERNAL = 3'b100,
		MODE_EXT_LOW = 3'b101,
		MODE_EXT_MED = 3'b110,
		MODE_EXT_HIGH = 3'b111
	} clk_mode_t;
	localparam logic [3:0] INTERNAL_FREQ_SELECT_FIELD_LF_MAX = 4'h1;
	localparam logic [3:0] INTERNAL_FREQ_SELECT_FIELD_HF_MIN = 4'h8;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int START_UP_CYCLES = 1024;
	localparam int HF_READY_NS = 1000;
	localparam int HF_LOCK_NS = 3000;
	localparam int HF_STABLE_NS = 6000;
	localparam int MF_READY_NS = 500;
	localparam int LF_READY_NS = 200;
	localparam int HF_READY_CYC = (HF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HF_LOCK_CYC = (HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HF_STABLE_CYC = (HF_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MF_READY_CYC = (MF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LF_READY_CYC = (LF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 12;

	typedef enum logic [1:0] {
		SU_IDLE = 2'b00,
		SU_WAIT_POWER_UP_DELAY_TIMER = 2'b01,
		SU_COUNT = 2'b10,
		SU_DONE = 2'b11
	} start_state_t;
endpackage

// >>> verilog/oscillator_source_control.sv
// Oscillator source control: start-up counter, PLL enable, internal oscillator status
// Function
// - Crystal modes count 1024 primary oscillator cycles
// - Count starts after power-up delay or wake
// - Hold CPU during count unless monitors enabled
// - With monitors, run from internal oscillator meanwhile
// - PLL on if either bit; config overrides
// - PLL takes external or internal input
// - Timer crystal selectable as system clock
// - Clock-out bit chooses secondary pin function in resistor-capacitor and internal modes
// - Internal mode frees primary pin for I/O
// - Internal block by config or select field
// - High-frequency clock derived from medium oscillator
// - Trim register adjusts high and medium oscillators
// - Frequency select drives postscaler multiplexer
// - Internal oscillators enabled by range and mode
// - Fast start-up clock until high oscillator is ready
// - High-frequency ready flag while running
// - High-frequency locked flag within two percent
// - High-frequency stable flag within half percent
// - Medium oscillator feeds nine postscaled frequencies
// - Medium-frequency ready flag while running
// - Low oscillator untrimmed at 31 kHz
// - External clock modes skip the start-up count
// - Codes 111, 110, 101 select external clock
// - Start-up status flag shows external source running
// - Select field 00/01/1x; clears on reset
`timescale 1ns/1ns
`default_nettype none
module oscillator_source_control #(
	parameter int START_COUNT = osc_ctrl_pkg::START_UP_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic primaryOscInputPin,
	input wire logic powerOnEvent,
	input wire logic powerUpTimerExpired,
	input wire logic sleepWakeEvent,
	output logic cpuHold,
	output logic runOnInternal,
	output logic pllEnable,
	output logic pllFromInternal,
	output logic [1:0] sysClkSource,
	output logic clockOutOnSecondaryPin,
	output logic primaryPinIsGpio,
	output logic highFreqOscEnable,
	output logic mediumFreqOscEnable,
	output logic lowFreqOscEnable,
	output logic fastStartClockActive,
	output logic [3:0] postscalerSelect,
	output logic [osc_ctrl_pkg::TRIM_W-1:0] frequencyTrim
);
	import osc_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic isCrystal(input logic [2:0] mode);
		isCrystal = (mode == MODE_WATCH_XTAL) || (mode == MODE_MED_XTAL) ||
			(mode == MODE_HIGH_XTAL);
	endfunction

	function automatic logic isExtLogic(input logic [2:0] mode);
		isExtLogic = (mode == MODE_EXT_LOW) || (mode == MODE_EXT_MED) ||
			(mode == MODE_EXT_HIGH);
	endfunction

	function automatic logic [11:0] settleStep(input logic [11:0] cnt, input logic on,
			input logic [11:0] limit);
		if (!on) begin
			settleStep = '0;
		end else if (cnt < limit) begin
			settleStep = cnt + 12'h001;
		end else begin
			settleStep = cnt;
		end
	endfunction

	localparam logic [11:0] HF_READY_LIM = 12'(HF_READY_CYC);
	localparam logic [11:0] HF_LOCK_LIM = 12'(HF_LOCK_CYC);
	localparam logic [11:0] HF_STABLE_LIM = 12'(HF_STABLE_CYC);
	localparam logic [11:0] MF_READY_LIM = 12'(MF_READY_CYC);
	localparam logic [11:0] LF_READY_LIM = 12'(LF_READY_CYC);
	localparam logic [10:0] COUNT_LAST = 11'(START_COUNT - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [1:0] sysClkSel, next_sysClkSel;
	logic [3:0] freqSel, next_freqSel;
	logic softPll, next_softPll;
	logic [TRIM_W-1:0] trim, next_trim;
	logic [7:0] cfgWord, next_cfgWord;
	logic wrPending, next_wrPending;
	logic [ADDR_W-1:0] wrAddr, next_wrAddr;
	logic [31:0] next_hrdata;
	logic pinMeta, pinSync, pinLast;
	start_state_t suState, next_suState;
	logic [10:0] suCount, next_suCount;
	logic [11:0] hfCnt, mfCnt, lfCnt, next_hfCnt, next_mfCnt, next_lfCnt;
	logic [2:0] mode;
	logic internalActive, hfRange, lfRange, mfOn, hfOn, lfOn, xtalDone, extRunning;
	logic [7:0] statusWord;

	// Field views of the configuration register
	assign mode = cfgWord[CFG_MODE_LSB +: 3];

	// Enable conditions for the internal block
	always_comb begin
		internalActive = (mode == MODE_INTERNAL) || sysClkSel[1];
		hfRange = freqSel >= INTERNAL_FREQ_SELECT_FIELD_HF_MIN;
		lfRange = freqSel <= INTERNAL_FREQ_SELECT_FIELD_LF_MAX;
		hfOn = internalActive && hfRange;
		mfOn = internalActive && !lfRange;
		lfOn = internalActive && lfRange;
		xtalDone = suState == SU_DONE;
		extRunning = (sysClkSel == SCS_CONFIGURED) && !(mode == MODE_INTERNAL) &&
			(!isCrystal(mode) || xtalDone);
	end

	// Status word; ready levels follow the running oscillators
	always_comb begin
		statusWord = '0;
		statusWord[STS_START_BIT] = extRunning;
		statusWord[STS_LF_READY_BIT] = lfCnt == LF_READY_LIM;
		statusWord[STS_HF_STABLE_BIT] = hfCnt == HF_STABLE_LIM;
		statusWord[STS_HF_LOCKED_BIT] = hfCnt >= HF_LOCK_LIM;
		statusWord[STS_MF_READY_BIT] = mfCnt == MF_READY_LIM;
		statusWord[STS_HF_READY_BIT] = hfCnt >= HF_READY_LIM;
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	// Zero wait states: reads are captured in the address phase
	always_comb begin
		next_wrPending = 1'b0;
		next_wrAddr = wrAddr;
		next_hrdata = hrdata;
		next_sysClkSel = sysClkSel;
		next_freqSel = freqSel;
		next_softPll = softPll;
		next_trim = trim;
		next_cfgWord = cfgWord;
		if (wrPending) begin
			case (wrAddr)
				ADDR_CONTROL: begin
					next_sysClkSel = hwdata[CTL_SCS_LSB +: 2];
					next_freqSel = hwdata[CTL_INTERNAL_FREQ_SELECT_FIELD_LSB +: 4];
					next_softPll = hwdata[CTL_SPLL_BIT];
				end
				ADDR_TRIM: next_trim = hwdata[TRIM_W-1:0];
				ADDR_CONFIG: next_cfgWord = hwdata[7:0];
				default: ;
			endcase
		end
		if (hsel && htrans[1] && hready) begin
			next_wrPending = hwrite;
			next_wrAddr = haddr[ADDR_W-1:0];
			next_hrdata = '0;
			if (!hwrite) begin
				case (haddr[ADDR_W-1:0])
					ADDR_CONTROL: begin
						next_hrdata[CTL_SCS_LSB +: 2] = sysClkSel;
						next_hrdata[CTL_INTERNAL_FREQ_SELECT_FIELD_LSB +: 4] = freqSel;
						next_hrdata[CTL_SPLL_BIT] = softPll;
					end
					ADDR_STATUS: next_hrdata[7:0] = statusWord;
					ADDR_TRIM: next_hrdata[TRIM_W-1:0] = trim;
					ADDR_CONFIG: next_hrdata[7:0] = cfgWord;
					default: next_hrdata = '0;
				endcase
			end
		end
	end

	// Register file and bus response; select field clears on every reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			wrPending <= 1'b0;
			wrAddr <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			sysClkSel <= SCS_RESET;
			freqSel <= INTERNAL_FREQ_SELECT_FIELD_RESET;
			softPll <= 1'b0;
			trim <= TRIM_RESET;
			cfgWord <= CFG_RESET;
		end else begin
			wrPending <= next_wrPending;
			wrAddr <= next_wrAddr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			sysClkSel <= next_sysClkSel;
			freqSel <= next_freqSel;
			softPll <= next_softPll;
			trim <= next_trim;
			cfgWord <= next_cfgWord;
		end
	end

	// ----------------------------------------------------------------
	// Primary oscillator pin synchroniser
	// ----------------------------------------------------------------
	// The pin is asynchronous; only the second and third stages are looked at
	always_ff @(posedge mclk) begin
		if (rst) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
			pinLast <= 1'b0;
		end else begin
			pinMeta <= primaryOscInputPin;
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end

	// ----------------------------------------------------------------
	// Start-up counter
	// ----------------------------------------------------------------
	// Every start event restarts the count from zero, even mid-count
	always_comb begin
		next_suState = suState;
		next_suCount = suCount;
		if (!isCrystal(mode)) begin
			next_suState = SU_DONE;
			next_suCount = '0;
		end else if (powerOnEvent) begin
			next_suState = cfgWord[CFG_POWER_UP_DELAY_TIMER_BIT] ? SU_WAIT_POWER_UP_DELAY_TIMER : SU_COUNT;
			next_suCount = '0;
		end else if (sleepWakeEvent) begin
			next_suState = SU_COUNT;
			next_suCount = '0;
		end else begin
			case (suState)
				SU_IDLE: next_suState = SU_IDLE;
				SU_WAIT_POWER_UP_DELAY_TIMER: begin
					if (powerUpTimerExpired) begin
						next_suState = SU_COUNT;
					end
				end
				SU_COUNT: begin
					if (pinSync && !pinLast) begin
						if (suCount == COUNT_LAST) begin
							next_suState = SU_DONE;
						end else begin
							next_suCount = suCount + 11'h001;
						end
					end
				end
				SU_DONE: next_suState = SU_DONE;
				default: next_suState = SU_IDLE;
			endcase
		end
	end

	// Counter registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			suState <= SU_IDLE;
			suCount <= '0;
		end else begin
			suState <= next_suState;
			suCount <= next_suCount;
		end
	end

	// ----------------------------------------------------------------
	// Internal oscillator settling
	// ----------------------------------------------------------------
	// High oscillator only settles once the medium source it derives from runs
	always_comb begin
		next_hfCnt = settleStep(hfCnt, hfOn && (mfCnt == MF_READY_LIM), HF_STABLE_LIM);
		next_mfCnt = settleStep(mfCnt, mfOn, MF_READY_LIM);
		next_lfCnt = settleStep(lfCnt, lfOn, LF_READY_LIM);
	end

	// Settling counters
	always_ff @(posedge mclk) begin
		if (rst) begin
			hfCnt <= '0;
			mfCnt <= '0;
			lfCnt <= '0;
		end else begin
			hfCnt <= next_hfCnt;
			mfCnt <= next_mfCnt;
			lfCnt <= next_lfCnt;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// All outputs come from flops, so they lag their cause by one cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			cpuHold <= 1'b0;
			runOnInternal <= 1'b0;
			pllEnable <= 1'b0;
			pllFromInternal <= 1'b0;
			sysClkSource <= SCS_RESET;
			clockOutOnSecondaryPin <= 1'b0;
			primaryPinIsGpio <= 1'b0;
			highFreqOscEnable <= 1'b0;
			mediumFreqOscEnable <= 1'b0;
			lowFreqOscEnable <= 1'b0;
			fastStartClockActive <= 1'b0;
			postscalerSelect <= INTERNAL_FREQ_SELECT_FIELD_RESET;
			frequencyTrim <= TRIM_RESET;
		end else begin
			cpuHold <= (next_suState != SU_DONE) && isCrystal(mode) &&
				!(cfgWord[CFG_FAILSAFE_BIT] || cfgWord[CFG_TWOSPEED_BIT]);
			runOnInternal <= (next_suState != SU_DONE) && isCrystal(mode) &&
				(cfgWord[CFG_FAILSAFE_BIT] || cfgWord[CFG_TWOSPEED_BIT]);
			pllEnable <= cfgWord[CFG_PLL_BIT] || softPll;
			pllFromInternal <= internalActive && !sysClkSel[1];
			sysClkSource <= sysClkSel;
			clockOutOnSecondaryPin <= !isCrystal(mode) && !isExtLogic(mode) &&
				cfgWord[CFG_CLKOUT_BIT];
			primaryPinIsGpio <= mode == MODE_INTERNAL;
			highFreqOscEnable <= hfOn;
			mediumFreqOscEnable <= mfOn;
			lowFreqOscEnable <= lfOn;
			fastStartClockActive <= hfOn && (hfCnt < HF_READY_LIM);
			postscalerSelect <= freqSel;
			frequencyTrim <= trim;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence counting_s;
		suState == SU_COUNT;
	endsequence
	sequence wake_s;
		sleepWakeEvent && isCrystal(mode) && !powerOnEvent;
	endsequence
	// Counting with no start event and no pin edge in this cycle
	sequence quiet_count_s;
		counting_s ##0 (isCrystal(mode) && !powerOnEvent && !sleepWakeEvent &&
			!(pinSync && !pinLast));
	endsequence

	chk_wake_restart: assert property (@(posedge mclk) disable iff (rst)
		wake_s |=> counting_s ##0 (suCount == 11'h000))
		else $error("wake did not restart count");
	chk_count_done: assert property (@(posedge mclk) disable iff (rst)
		(suState == SU_COUNT && !powerOnEvent && !sleepWakeEvent && pinSync && !pinLast &&
		suCount == COUNT_LAST && isCrystal(mode)) |=> (suState == SU_DONE))
		else $error("count did not finish at last cycle");
	chk_no_early_done: assert property (@(posedge mclk) disable iff (rst)
		(suState == SU_COUNT && suCount != COUNT_LAST && isCrystal(mode)) |=>
		(suState != SU_DONE))
		else $error("count finished early");
	chk_cpu_hold: assert property (@(posedge mclk) disable iff (rst)
		quiet_count_s ##0 !(cfgWord[CFG_FAILSAFE_BIT] || cfgWord[CFG_TWOSPEED_BIT]) |=> cpuHold)
		else $error("cpu not held during count");
	chk_run_internal: assert property (@(posedge mclk) disable iff (rst)
		quiet_count_s ##0 (cfgWord[CFG_FAILSAFE_BIT] || cfgWord[CFG_TWOSPEED_BIT]) |=>
		runOnInternal && !cpuHold)
		else $error("not on internal clock during count");
	chk_pll_enable: assert property (@(posedge mclk) disable iff (rst)
		cfgWord[CFG_PLL_BIT] |=> pllEnable)
		else $error("config bit did not force pll");
	chk_ext_no_count: assert property (@(posedge mclk) disable iff (rst)
		isExtLogic(mode) |=> (suState == SU_DONE) && !cpuHold)
		else $error("external clock mode counted");
	chk_hf_flags: assert property (@(posedge mclk) disable iff (rst)
		statusWord[STS_HF_STABLE_BIT] |-> statusWord[STS_HF_LOCKED_BIT] &&
		statusWord[STS_HF_READY_BIT])
		else $error("hf flags out of order");
	chk_hf_needs_mf: assert property (@(posedge mclk) disable iff (rst)
		statusWord[STS_HF_READY_BIT] |-> statusWord[STS_MF_READY_BIT])
		else $error("hf ready without mf");
	chk_hf_off_clear: assert property (@(posedge mclk) disable iff (rst)
		!hfOn |=> !statusWord[STS_HF_READY_BIT])
		else $error("hf ready while disabled");
	chk_gpio_pin: assert property (@(posedge mclk) disable iff (rst)
		$changed(mode) |=> primaryPinIsGpio == ($past(mode) == MODE_INTERNAL))
		else $error("primary pin role wrong");
endmodule
`default_nettype wire

// >>> verification/xtal_model.sv
// Crystal or resonator stand-in that drives the primary oscillator input pin
`timescale 1ns/1ns
`default_nettype none
module xtal_model #(
	parameter int HALF_NS = 23
) (
	input wire logic running,
	output logic oscPin
);
	// ----------------------------------------------------------------
	// Oscillation
	// ----------------------------------------------------------------
	// Stopped crystal leaves the pin low, so a stalled start-up stays visible
	// Half period is unrelated to the system clock to exercise the synchroniser
	initial begin
		oscPin = 1'b0;
		forever begin
			#(HALF_NS);
			oscPin = running ? ~oscPin : 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking testbench for the oscillator source control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import osc_ctrl_pkg::*;
	localparam int SC = 16;
	localparam int XHALF = 23;
	// Start-up length window in system clocks, with room for synchroniser lag
	localparam int LO = (SC - 1) * 2 * XHALF / 10;
	localparam int HI = (SC + 1) * 2 * XHALF / 10 + 8;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic powerOnEvent = 1'b0;
	logic powerUpTimerExpired = 1'b0;
	logic sleepWakeEvent = 1'b0;
	logic xtalRun = 1'b0;
	logic oscPin;
	logic [31:0] hrdata;
	logic hreadyout, hresp, cpuHold, runOnInternal, pllEnable, pllFromInternal;
	logic clockOutOnSecondaryPin, primaryPinIsGpio, highFreqOscEnable;
	logic mediumFreqOscEnable, lowFreqOscEnable, fastStartClockActive;
	logic [1:0] sysClkSource;
	logic [3:0] postscalerSelect;
	logic [TRIM_W-1:0] frequencyTrim;
	logic [TRIM_W-1:0] trimV;
	logic [31:0] rdData;
	logic [31:0] expQ[$];
	event rdDone;
	int n_errors = 0;
	int compares = 0;

	always #5 mclk = ~mclk;

	xtal_model #(.HALF_NS(XHALF)) u_xtal (.running(xtalRun), .oscPin(oscPin));

	oscillator_source_control #(.START_COUNT(SC)) u_dut (
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.primaryOscInputPin(oscPin), .powerOnEvent(powerOnEvent),
		.powerUpTimerExpired(powerUpTimerExpired), .sleepWakeEvent(sleepWakeEvent),
		.cpuHold(cpuHold), .runOnInternal(runOnInternal), .pllEnable(pllEnable),
		.pllFromInternal(pllFromInternal), .sysClkSource(sysClkSource),
		.clockOutOnSecondaryPin(clockOutOnSecondaryPin),
		.primaryPinIsGpio(primaryPinIsGpio), .highFreqOscEnable(highFreqOscEnable),
		.mediumFreqOscEnable(mediumFreqOscEnable), .lowFreqOscEnable(lowFreqOscEnable),
		.fastStartClockActive(fastStartClockActive), .postscalerSelect(postscalerSelect),
		.frequencyTrim(frequencyTrim)
	);

	// ----------------------------------------------------------------
	// Checking and reporting
	// ----------------------------------------------------------------
	task automatic cmpOut(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cmpRd(input logic [31:0] exp, input logic [31:0] got);
		cmpOut(got, exp, "read data");
	endtask

	// Read results are matched against the oldest expectation noted by the driver
	always @(rdDone) begin
		cmpRd(expQ.pop_front(), rdData);
	end

	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Hang guard well beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------------------------------
	task automatic busXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hsize <= 3'h2;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		busXfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		expQ.push_back(exp);
		busXfer(1'b0, a, 32'h0, q);
		rdData = q;
		->rdDone;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Bits: power-on, power-up timer expired, wake from sleep
	task automatic pulse(input logic [2:0] ev);
		{powerOnEvent, powerUpTimerExpired, sleepWakeEvent} <= ev;
		@(posedge mclk);
		{powerOnEvent, powerUpTimerExpired, sleepWakeEvent} <= 3'h0;
		@(posedge mclk);
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] sel, input logic [3:0] internal_freq_select_field,
			input logic spll);
		return (32'(sel) << CTL_SCS_LSB) | (32'(internal_freq_select_field) << CTL_INTERNAL_FREQ_SELECT_FIELD_LSB) |
			(32'(spll) << CTL_SPLL_BIT);
	endfunction

	// Length of one start-up count, seen on the hold or the run-on-internal output
	task automatic measure(input bit viaRun);
		int len;
		len = 0;
		while ((viaRun ? runOnInternal : cpuHold) !== 1'b1 && len < 20) begin
			@(posedge mclk);
			len++;
		end
		cmpOut(32'(viaRun ? cpuHold : runOnInternal), 32'h0, "other busy");
		len = 0;
		while ((viaRun ? runOnInternal : cpuHold) === 1'b1 && len < 2000) begin
			@(posedge mclk);
			len++;
		end
		cmpOut(32'(len >= LO && len <= HI), 32'h1, "count length");
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(5));
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(ADDR_CONTROL, 32'(INTERNAL_FREQ_SELECT_FIELD_RESET) << CTL_INTERNAL_FREQ_SELECT_FIELD_LSB);
		rd(ADDR_CONFIG, 32'(CFG_RESET));
		cmpOut(32'(postscalerSelect), 32'(INTERNAL_FREQ_SELECT_FIELD_RESET), "internal_freq_select_field");
		cmpOut(32'(mediumFreqOscEnable), 32'h1, "mf on");
		cmpOut(32'({hreadyout, hresp}), 32'h2, "bus response");
		$display("test reset done");
		trimV = TRIM_W'($urandom);
		wr(ADDR_TRIM, 32'(trimV));
		rd(ADDR_TRIM, 32'(trimV));
		cmpOut(32'(frequencyTrim), 32'(trimV), "trim");
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CONFIG, 32'(CFG_RESET) | (32'(i[1]) << CFG_PLL_BIT));
			wr(ADDR_CONTROL, ctl(2'h0, INTERNAL_FREQ_SELECT_FIELD_RESET, i[0]));
			cyc(4);
			cmpOut(32'(pllEnable), 32'(i[1] | i[0]), "pll");
		end
		$display("test pll done");
		wr(ADDR_CONTROL, ctl(2'h0, 4'hF, 1'b0));
		cyc(4);
		cmpOut(32'({highFreqOscEnable, fastStartClockActive, pllFromInternal}), 32'h7,
			"hf start");
		cmpOut(32'(postscalerSelect), 32'hF, "internal_freq_select_field set");
		cyc(900);
		cmpOut(32'(fastStartClockActive), 32'h0, "fast start");
		rd(ADDR_STATUS, (32'h1 << STS_HF_READY_BIT) | (32'h1 << STS_HF_LOCKED_BIT) |
			(32'h1 << STS_HF_STABLE_BIT) | (32'h1 << STS_MF_READY_BIT));
		wr(ADDR_CONTROL, ctl(2'h0, 4'h0, 1'b0));
		cyc(4);
		cmpOut(32'({lowFreqOscEnable, highFreqOscEnable}), 32'h2, "lf on");
		wr(ADDR_CONTROL, ctl(2'h2, 4'h0, 1'b0));
		cyc(4);
		cmpOut(32'({sysClkSource, pllFromInternal}), 32'h4, "internal");
		wr(ADDR_CONTROL, ctl(2'h1, 4'h0, 1'b0));
		cyc(4);
		cmpOut(32'(sysClkSource), 32'h1, "timer xtal");
		wr(ADDR_CONFIG, 32'(MODE_EXT_HIGH));
		wr(ADDR_CONTROL, ctl(2'h0, 4'hF, 1'b0));
		cyc(4);
		cmpOut(32'(highFreqOscEnable), 32'h0, "hf off");
		wr(ADDR_CONTROL, ctl(2'h2, 4'hF, 1'b0));
		cyc(4);
		cmpOut(32'(highFreqOscEnable), 32'h1, "hf by select");
		$display("test internal done");
		for (int m = 0; m < 16; m++) begin
			wr(ADDR_CONFIG, 32'(m[2:0]) | (32'(m[3]) << CFG_CLKOUT_BIT));
			cyc(4);
			cmpOut(32'(clockOutOnSecondaryPin), 32'(m[3] && (m[2:0] inside {3, 4})),
				"clock out");
			cmpOut(32'(primaryPinIsGpio), 32'(m[2:0] == 3'h4), "gpio");
		end
		$display("test pins done");
		xtalRun <= 1'b1;
		wr(ADDR_CONTROL, ctl(2'h0, INTERNAL_FREQ_SELECT_FIELD_RESET, 1'b0));
		for (int f = 0; f < 3; f++) begin
			wr(ADDR_CONFIG, 32'(MODE_MED_XTAL) | (f == 0 ? 32'h0 :
				32'h1 << (CFG_FAILSAFE_BIT + f - 1)));
			pulse(3'b001);
			measure(f != 0);
			rd(ADDR_STATUS, 32'h1 << STS_START_BIT);
		end
		wr(ADDR_CONFIG, 32'(MODE_WATCH_XTAL));
		xtalRun <= 1'b0;
		// Let the last pin edge drain through the synchroniser before the wake
		cyc(8);
		pulse(3'b001);
		cyc(200);
		cmpOut(32'(cpuHold), 32'h1, "stalled hold");
		rd(ADDR_STATUS, 32'h0);
		xtalRun <= 1'b1;
		measure(1'b0);
		wr(ADDR_CONFIG, 32'(MODE_HIGH_XTAL) | (32'h1 << CFG_POWER_UP_DELAY_TIMER_BIT));
		pulse(3'b100);
		cyc(150);
		rd(ADDR_STATUS, 32'h0);
		pulse(3'b010);
		measure(1'b0);
		$display("test start-up done");
		for (int m = 5; m < 8; m++) begin
			wr(ADDR_CONFIG, 32'(m));
			pulse(3'b001);
			cyc(3);
			cmpOut(32'(cpuHold), 32'h0, "no hold");
			rd(ADDR_STATUS, 32'h1 << STS_START_BIT);
		end
		$display("test external clock done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
